// ### tpm_pkg.sv
package tpm_pkg;

	// time base
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned SEC_NS        = 1_000_000_000;
	localparam int unsigned SEC_TICKS     = SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned INTERVAL_MIN  = 15;
	localparam int unsigned INTERVAL_SEC  = INTERVAL_MIN * 60;

	// history and counter shape
	localparam int unsigned HIST_DEPTH = 96;
	localparam int unsigned NUM_CNT    = 6;
	localparam int unsigned CW         = 10;
	localparam int unsigned TW         = 17;
	localparam int unsigned ST_W       = 5;
	localparam int unsigned EW         = NUM_CNT * CW + ST_W;

	// limits and thresholds
	localparam logic [9:0]  CNT_MAX       = 10'h384;
	localparam logic [9:0]  LOF_EVT_MAX   = 10'h0FF;
	localparam logic [15:0] EVT_MAX       = 16'hFFFF;
	localparam logic [3:0]  UAS_RUN       = 4'hA;
	localparam logic [9:0]  T1_SES_CRC    = 10'h140;
	localparam logic [9:0]  E1_SES_CRC    = 10'h325;
	localparam logic [4:0]  E1_SES_FAS    = 5'h10;

	// counter slots
	localparam int unsigned CI_ERRORED = 0;
	localparam int unsigned CI_UNAVAIL = 1;
	localparam int unsigned CI_SEVERE  = 2;
	localparam int unsigned CI_BURSTY  = 3;
	localparam int unsigned CI_SLIP    = 4;
	localparam int unsigned CI_FRLOSS  = 5;

	// status history bits
	localparam int unsigned ST_RAI    = 0;
	localparam int unsigned ST_LOS    = 1;
	localparam int unsigned ST_EXCESS = 2;
	localparam int unsigned ST_FBIT   = 3;
	localparam int unsigned ST_LCV    = 4;

	// register map
	localparam int unsigned ADDR_W     = 12;
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_TIMER  = 12'h004;
	localparam logic [11:0] OFF_EVENTS = 12'h008;
	localparam logic [11:0] OFF_STATUS = 12'h00C;
	localparam logic [11:0] OFF_HSEL   = 12'h010;
	localparam logic [11:0] OFF_HSTAT  = 12'h014;
	localparam logic [11:0] OFF_CUR    = 12'h020;
	localparam logic [11:0] OFF_HIST   = 12'h040;
	localparam logic [11:0] OFF_WORST  = 12'h060;
	localparam logic [11:0] OFF_TOTAL  = 12'h080;

	// control and status fields
	localparam int unsigned CB_EN    = 0;
	localparam int unsigned CB_E1    = 1;
	localparam int unsigned CB_FRM   = 2;
	localparam int unsigned CB_CRC   = 3;
	localparam int unsigned CB_CLEAR = 4;
	localparam logic [3:0]  CTRL_RST = 4'h0;
	localparam int unsigned SB_UNAV  = 8;
	localparam int unsigned SB_VALID = 16;

	typedef enum logic {TPM_SC_IDLE, TPM_SC_RUN} tpm_scan_e;

endpackage

// ### tpm_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module tpm_monitor #(
	parameter int unsigned TICKS_PER_SEC = tpm_pkg::SEC_TICKS,
	parameter int unsigned INTERVAL_SECS = tpm_pkg::INTERVAL_SEC,
	parameter int unsigned HIST_DEPTH    = tpm_pkg::HIST_DEPTH
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [tpm_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        crc_err_evt,
	input  wire logic                        oof_evt,
	input  wire logic                        lof_evt,
	input  wire logic                        slip_evt,
	input  wire logic                        los_evt,
	input  wire logic                        ais_evt,
	input  wire logic                        fas_err_evt,
	input  wire logic                        rai_evt,
	input  wire logic                        excess_err_evt,
	input  wire logic                        fbit_err_evt,
	input  wire logic                        lcv_evt,
	output logic                             line_unavailable
);
	import tpm_pkg::*;

	localparam int HW = $clog2(HIST_DEPTH + 1);
	localparam int PW = $clog2(HIST_DEPTH);
	localparam logic [31:0] DIV_LAST = 32'(TICKS_PER_SEC - 1);
	localparam logic [9:0]  TMR_LAST = 10'(INTERVAL_SECS - 1);
	localparam logic [HW-1:0] DEPTH_V = HW'(HIST_DEPTH);

	function automatic logic [CW-1:0] sat_add(input logic [CW-1:0] a,
	                                          input logic [CW-1:0] b,
	                                          input logic [CW-1:0] lim);
		logic [CW:0] s;
		s = {1'b0, a} + {1'b0, b};
		return (s > {1'b0, lim}) ? lim : s[CW-1:0];
	endfunction

	// control registers
	logic            ctrl_en_q, ctrl_e1_q, ctrl_frm_q, ctrl_crc_q;
	logic [HW-1:0]   hist_sel_q;
	logic            clear_pulse;
	logic            collecting;
	logic            flush;

	// the framing select means ESF on T1 and framed mode on E1
	assign collecting = ctrl_en_q & ctrl_frm_q;
	assign flush      = ~collecting | clear_pulse;

	// ---------------- second tick and interval timer
	logic [31:0] div_q, div_d;
	logic [9:0]  timer_q, timer_d;
	logic        sec_tick, boundary;

	always_comb begin
		div_d    = div_q + 32'h1;
		sec_tick = 1'b0;
		if (!collecting) begin
			div_d = 32'h0;
		end else if (div_q == DIV_LAST) begin
			div_d    = 32'h0;
			sec_tick = 1'b1;
		end
		timer_d  = timer_q;
		boundary = 1'b0;
		if (flush) begin
			timer_d = 10'h0;
		end else if (sec_tick) begin
			if (timer_q == TMR_LAST) begin
				timer_d  = 10'h0;
				boundary = 1'b1;
			end else begin
				timer_d = timer_q + 10'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q   <= 32'h0;
			timer_q <= 10'h0;
		end else begin
			div_q   <= div_d;
			timer_q <= timer_d;
		end
	end

	// ---------------- per-second accumulation and current interval
	logic [9:0]    crc_sec_q, crc_sec_d;
	logic [4:0]    fas_sec_q, fas_sec_d;
	logic          oof_q, oof_d, lof_q, lof_d, slip_q, slip_d;
	logic          losais_q, losais_d;
	logic [CW-1:0] cur_q [NUM_CNT];
	logic [CW-1:0] cur_d [NUM_CNT];
	logic [CW-1:0] cnt_new [NUM_CNT];
	logic [ST_W-1:0] st_q, st_d, st_new;
	logic [15:0]   evt_q, evt_d;
	logic [3:0]    ses_run_q, ses_run_d, clr_run_q, clr_run_d;
	logic          unav_q, unav_d;
	logic          is_es, is_ses, is_bes;
	logic [16:0]   evt_sum;

	always_comb begin
		// classification of the second that just ended
		if (!ctrl_e1_q) begin
			is_es  = (crc_sec_q != 10'h0) | oof_q;
			is_ses = (crc_sec_q >= T1_SES_CRC) | oof_q;
			is_bes = (crc_sec_q > 10'h1) & (crc_sec_q < T1_SES_CRC);
		end else begin
			is_es  = (crc_sec_q != 10'h0);
			is_ses = (crc_sec_q >= E1_SES_CRC) | (fas_sec_q >= E1_SES_FAS)
			       | losais_q;
			if (ctrl_crc_q) begin
				is_bes = (crc_sec_q > 10'h1) & (crc_sec_q < E1_SES_CRC);
			end else begin
				is_bes = (fas_sec_q > 5'h1) & (fas_sec_q < E1_SES_FAS);
			end
		end

		for (int c = 0; c < NUM_CNT; c++) begin
			cnt_new[c] = cur_q[c];
		end
		ses_run_d = ses_run_q;
		clr_run_d = clr_run_q;
		unav_d    = unav_q;
		// T1 counts declarations as they happen, not per second
		if (!ctrl_e1_q && lof_evt) begin
			cnt_new[CI_FRLOSS] = sat_add(cur_q[CI_FRLOSS], 10'h1,
			                             LOF_EVT_MAX);
		end
		if (sec_tick) begin
			if (is_es) begin
				cnt_new[CI_ERRORED] = sat_add(cur_q[CI_ERRORED], 10'h1,
				                              CNT_MAX);
			end
			if (is_ses) begin
				cnt_new[CI_SEVERE] = sat_add(cur_q[CI_SEVERE], 10'h1,
				                             CNT_MAX);
			end
			if (is_bes) begin
				cnt_new[CI_BURSTY] = sat_add(cur_q[CI_BURSTY], 10'h1,
				                             CNT_MAX);
			end
			if (slip_q) begin
				cnt_new[CI_SLIP] = sat_add(cur_q[CI_SLIP], 10'h1,
				                           CNT_MAX);
			end
			if (ctrl_e1_q && lof_q) begin
				cnt_new[CI_FRLOSS] = sat_add(cur_q[CI_FRLOSS], 10'h1,
				                             CNT_MAX);
			end
			// the ten seconds that trigger a change are credited back,
			// so the count can drift across an interval edge
			if (!unav_q) begin
				if (is_ses) begin
					if (ses_run_q == UAS_RUN - 4'h1) begin
						unav_d    = 1'b1;
						ses_run_d = 4'h0;
						cnt_new[CI_UNAVAIL] = sat_add(cur_q[CI_UNAVAIL],
						                     10'(UAS_RUN), CNT_MAX);
					end else begin
						ses_run_d = ses_run_q + 4'h1;
					end
				end else begin
					ses_run_d = 4'h0;
				end
			end else if (!is_ses) begin
				if (clr_run_q == UAS_RUN - 4'h1) begin
					unav_d    = 1'b0;
					clr_run_d = 4'h0;
					if (cur_q[CI_UNAVAIL] > 10'(UAS_RUN - 4'h1)) begin
						cnt_new[CI_UNAVAIL] = cur_q[CI_UNAVAIL]
						                    - 10'(UAS_RUN - 4'h1);
					end else begin
						cnt_new[CI_UNAVAIL] = 10'h0;
					end
				end else begin
					clr_run_d = clr_run_q + 4'h1;
					cnt_new[CI_UNAVAIL] = sat_add(cur_q[CI_UNAVAIL], 10'h1,
					                              CNT_MAX);
				end
			end else begin
				clr_run_d = 4'h0;
				cnt_new[CI_UNAVAIL] = sat_add(cur_q[CI_UNAVAIL], 10'h1,
				                              CNT_MAX);
			end
		end

		// events of this cycle land in the flags before any clear
		st_new = st_q;
		st_new[ST_RAI]    = st_q[ST_RAI] | rai_evt;
		st_new[ST_LOS]    = st_q[ST_LOS] | los_evt;
		st_new[ST_EXCESS] = st_q[ST_EXCESS] | excess_err_evt;
		st_new[ST_FBIT]   = st_q[ST_FBIT] | fbit_err_evt;
		st_new[ST_LCV]    = st_q[ST_LCV] | lcv_evt;

		// a new second starts with the events of the tick cycle
		crc_sec_d = sec_tick ? {9'h0, crc_err_evt} :
		            ((crc_sec_q == 10'h3FF) ? crc_sec_q
		             : crc_sec_q + {9'h0, crc_err_evt});
		fas_sec_d = sec_tick ? {4'h0, fas_err_evt} :
		            ((fas_sec_q == 5'h1F) ? fas_sec_q
		             : fas_sec_q + {4'h0, fas_err_evt});
		oof_d    = (oof_q & ~sec_tick) | oof_evt;
		lof_d    = (lof_q & ~sec_tick) | lof_evt;
		slip_d   = (slip_q & ~sec_tick) | slip_evt;
		losais_d = (losais_q & ~sec_tick) | los_evt | ais_evt;

		evt_sum = {1'b0, evt_q} + {16'h0, crc_err_evt}
		        + {16'h0, oof_evt & ~ctrl_e1_q};
		evt_d   = evt_sum[16] ? EVT_MAX : evt_sum[15:0];

		for (int c = 0; c < NUM_CNT; c++) begin
			cur_d[c] = boundary ? '0 : cnt_new[c];
		end
		st_d = boundary ? '0 : st_new;

		if (flush) begin
			for (int c = 0; c < NUM_CNT; c++) begin
				cur_d[c] = '0;
			end
			st_d      = '0;
			evt_d     = 16'h0;
			crc_sec_d = 10'h0;
			fas_sec_d = 5'h0;
			oof_d     = 1'b0;
			lof_d     = 1'b0;
			slip_d    = 1'b0;
			losais_d  = 1'b0;
			ses_run_d = 4'h0;
			clr_run_d = 4'h0;
			unav_d    = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NUM_CNT; c++) begin
				cur_q[c] <= '0;
			end
			st_q      <= '0;
			evt_q     <= 16'h0;
			crc_sec_q <= 10'h0;
			fas_sec_q <= 5'h0;
			oof_q     <= 1'b0;
			lof_q     <= 1'b0;
			slip_q    <= 1'b0;
			losais_q  <= 1'b0;
			ses_run_q <= 4'h0;
			clr_run_q <= 4'h0;
			unav_q    <= 1'b0;
		end else begin
			cur_q     <= cur_d;
			st_q      <= st_d;
			evt_q     <= evt_d;
			crc_sec_q <= crc_sec_d;
			fas_sec_q <= fas_sec_d;
			oof_q     <= oof_d;
			lof_q     <= lof_d;
			slip_q    <= slip_d;
			losais_q  <= losais_d;
			ses_run_q <= ses_run_d;
			clr_run_q <= clr_run_d;
			unav_q    <= unav_d;
		end
	end

	assign line_unavailable = unav_q;

	// ---------------- interval history
	// a ring with a write pointer ages every entry at once
	logic [EW-1:0]  hist_mem [HIST_DEPTH];
	logic [EW-1:0]  hist_entry;
	logic [PW-1:0]  wr_ptr_q, wr_ptr_d;
	logic [HW-1:0]  valid_q, valid_d;

	function automatic logic [PW-1:0] hist_addr(input logic [PW-1:0] wp,
	                                            input logic [HW-1:0] idx);
		logic [PW+1:0] t;
		t = {2'b0, wp} + (PW+2)'(HIST_DEPTH) - (PW+2)'(idx);
		if (t >= (PW+2)'(HIST_DEPTH)) begin
			t = t - (PW+2)'(HIST_DEPTH);
		end
		return t[PW-1:0];
	endfunction

	always_comb begin
		for (int c = 0; c < NUM_CNT; c++) begin
			hist_entry[c*CW +: CW] = cnt_new[c];
		end
		hist_entry[NUM_CNT*CW +: ST_W] = st_new;
		wr_ptr_d = wr_ptr_q;
		valid_d  = valid_q;
		if (flush) begin
			valid_d  = '0;
			wr_ptr_d = '0;
		end else if (boundary) begin
			wr_ptr_d = (wr_ptr_q == PW'(HIST_DEPTH - 1)) ? '0
			         : wr_ptr_q + PW'(1);
			valid_d  = (valid_q == DEPTH_V) ? valid_q
			         : valid_q + HW'(1);
		end
	end

	always_ff @(posedge pclk) begin
		if (boundary && !flush) begin
			hist_mem[wr_ptr_q] <= hist_entry;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_q <= '0;
			valid_q  <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			valid_q  <= valid_d;
		end
	end

	// ---------------- worst and total scan
	// one entry per cycle from oldest to newest; results lag a boundary
	// by about a hundred cycles, far below one second
	tpm_scan_e      scan_q, scan_d;
	logic           rescan_q, rescan_d;
	logic [HW-1:0]  scan_i_q, scan_i_d;
	logic [EW-1:0]  scan_ent;
	logic [TW-1:0]  acc_tot_q [NUM_CNT];
	logic [TW-1:0]  acc_tot_d [NUM_CNT];
	logic [CW-1:0]  acc_wv_q [NUM_CNT];
	logic [CW-1:0]  acc_wv_d [NUM_CNT];
	logic [HW-1:0]  acc_wi_q [NUM_CNT];
	logic [HW-1:0]  acc_wi_d [NUM_CNT];
	logic [TW-1:0]  tot_q [NUM_CNT];
	logic [TW-1:0]  tot_d [NUM_CNT];
	logic [HW-1:0]  worst_q [NUM_CNT];
	logic [HW-1:0]  worst_d [NUM_CNT];

	assign scan_ent = hist_mem[hist_addr(wr_ptr_q, scan_i_q)];

	always_comb begin
		rescan_d  = boundary | flush;
		scan_d    = scan_q;
		scan_i_d  = scan_i_q;
		acc_tot_d = acc_tot_q;
		acc_wv_d  = acc_wv_q;
		acc_wi_d  = acc_wi_q;
		tot_d     = tot_q;
		worst_d   = worst_q;
		if (rescan_q) begin
			scan_d   = TPM_SC_RUN;
			scan_i_d = valid_q;
			for (int c = 0; c < NUM_CNT; c++) begin
				acc_tot_d[c] = '0;
				acc_wv_d[c]  = '0;
				acc_wi_d[c]  = '0;
			end
		end else begin
			case (scan_q)
				TPM_SC_IDLE: begin
					scan_d = TPM_SC_IDLE;
				end
				TPM_SC_RUN: begin
					if (scan_i_q == '0) begin
						scan_d  = TPM_SC_IDLE;
						tot_d   = acc_tot_q;
						worst_d = acc_wi_q;
					end else begin
						scan_i_d = scan_i_q - HW'(1);
						for (int c = 0; c < NUM_CNT; c++) begin
							acc_tot_d[c] = acc_tot_q[c]
							             + TW'(scan_ent[c*CW +: CW]);
							// strictly greater keeps the older on a tie
							if (acc_wi_q[c] == '0
							    || scan_ent[c*CW +: CW] > acc_wv_q[c]) begin
								acc_wv_d[c] = scan_ent[c*CW +: CW];
								acc_wi_d[c] = scan_i_q;
							end
						end
					end
				end
				default: begin
					scan_d = TPM_SC_IDLE;
				end
			endcase
		end
		// a disabled or cleared port shows no worst or total at once
		if (flush) begin
			for (int c = 0; c < NUM_CNT; c++) begin
				tot_d[c]   = '0;
				worst_d[c] = '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_q   <= TPM_SC_IDLE;
			rescan_q <= 1'b0;
			scan_i_q <= '0;
			for (int c = 0; c < NUM_CNT; c++) begin
				acc_tot_q[c] <= '0;
				acc_wv_q[c]  <= '0;
				acc_wi_q[c]  <= '0;
				tot_q[c]     <= '0;
				worst_q[c]   <= '0;
			end
		end else begin
			scan_q    <= scan_d;
			rescan_q  <= rescan_d;
			scan_i_q  <= scan_i_d;
			acc_tot_q <= acc_tot_d;
			acc_wv_q  <= acc_wv_d;
			acc_wi_q  <= acc_wi_d;
			tot_q     <= tot_d;
			worst_q   <= worst_d;
		end
	end

	// ---------------- APB slave
	// read data is captured in the setup cycle so prdata is a flop and
	// every access completes with no wait state
	logic [31:0]     rd_d, prdata_q;
	logic            err_d, pslverr_q;
	logic            setup, access;
	logic            sel_ok;
	logic [EW-1:0]   sel_ent;
	logic [ADDR_W-1:0] off;
	logic [2:0]      k;
	logic            ctrl_en_d, ctrl_e1_d, ctrl_frm_d, ctrl_crc_d;
	logic [HW-1:0]   hist_sel_d;

	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign sel_ok = (hist_sel_q != '0) && (hist_sel_q <= valid_q);
	assign sel_ent = hist_mem[hist_addr(wr_ptr_q, hist_sel_q)];

	always_comb begin
		rd_d  = 32'h0;
		err_d = 1'b0;
		off   = '0;
		if (paddr[1:0] != 2'h0) begin
			err_d = 1'b1;
		end else if (paddr == OFF_CTRL) begin
			rd_d[CB_EN]  = ctrl_en_q;
			rd_d[CB_E1]  = ctrl_e1_q;
			rd_d[CB_FRM] = ctrl_frm_q;
			rd_d[CB_CRC] = ctrl_crc_q;
		end else if (paddr == OFF_TIMER) begin
			rd_d[9:0] = timer_q;
		end else if (paddr == OFF_EVENTS) begin
			rd_d[15:0] = evt_q;
		end else if (paddr == OFF_STATUS) begin
			rd_d[ST_W-1:0]            = st_q;
			rd_d[SB_UNAV]             = unav_q;
			rd_d[SB_VALID +: HW]      = valid_q;
		end else if (paddr == OFF_HSEL) begin
			rd_d[HW-1:0] = hist_sel_q;
		end else if (paddr == OFF_HSTAT) begin
			if (sel_ok) begin
				rd_d[ST_W-1:0] = sel_ent[NUM_CNT*CW +: ST_W];
			end
		end else if (paddr >= OFF_CUR && paddr < OFF_CUR + 12'h018) begin
			off = paddr - OFF_CUR;
		end else if (paddr >= OFF_HIST && paddr < OFF_HIST + 12'h018) begin
			off = paddr - OFF_HIST;
		end else if (paddr >= OFF_WORST && paddr < OFF_WORST + 12'h018) begin
			off = paddr - OFF_WORST;
		end else if (paddr >= OFF_TOTAL && paddr < OFF_TOTAL + 12'h018) begin
			off = paddr - OFF_TOTAL;
		end else begin
			err_d = 1'b1;
		end
		k = off[4:2];
		// a refused access must read zero, even inside a counter window
		if (err_d) begin
			rd_d = 32'h0;
		end else if (paddr >= OFF_CUR && paddr < OFF_CUR + 12'h018) begin
			rd_d[CW-1:0] = cur_q[k];
		end else if (paddr >= OFF_HIST && paddr < OFF_HIST + 12'h018) begin
			rd_d[CW-1:0] = sel_ok ? sel_ent[k*CW +: CW] : '0;
		end else if (paddr >= OFF_WORST && paddr < OFF_WORST + 12'h018) begin
			rd_d[HW-1:0] = worst_q[k];
		end else if (paddr >= OFF_TOTAL && paddr < OFF_TOTAL + 12'h018) begin
			rd_d[TW-1:0] = tot_q[k];
		end

		ctrl_en_d   = ctrl_en_q;
		ctrl_e1_d   = ctrl_e1_q;
		ctrl_frm_d  = ctrl_frm_q;
		ctrl_crc_d  = ctrl_crc_q;
		hist_sel_d  = hist_sel_q;
		clear_pulse = 1'b0;
		if (access && pwrite && paddr == OFF_CTRL) begin
			ctrl_en_d   = pwdata[CB_EN];
			ctrl_e1_d   = pwdata[CB_E1];
			ctrl_frm_d  = pwdata[CB_FRM];
			ctrl_crc_d  = pwdata[CB_CRC];
			clear_pulse = pwdata[CB_CLEAR];
		end else if (access && pwrite && paddr == OFF_HSEL) begin
			hist_sel_d = pwdata[HW-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q   <= 32'h0;
			pslverr_q  <= 1'b0;
			ctrl_en_q  <= CTRL_RST[CB_EN];
			ctrl_e1_q  <= CTRL_RST[CB_E1];
			ctrl_frm_q <= CTRL_RST[CB_FRM];
			ctrl_crc_q <= CTRL_RST[CB_CRC];
			hist_sel_q <= '0;
		end else begin
			prdata_q   <= setup ? rd_d : prdata_q;
			pslverr_q  <= setup ? err_d : (access ? pslverr_q : 1'b0);
			ctrl_en_q  <= ctrl_en_d;
			ctrl_e1_q  <= ctrl_e1_d;
			ctrl_frm_q <= ctrl_frm_d;
			ctrl_crc_q <= ctrl_crc_d;
			hist_sel_q <= hist_sel_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = pslverr_q & access;

endmodule

`default_nettype wire

// ### tpm_chk_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tpm_chk
	import tpm_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        line_unavailable
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_acc;
		psel && penable;
	endsequence
	// disable or clear written to control
	sequence s_off;
		psel && penable && pwrite && paddr == OFF_CTRL
		&& (!pwdata[CB_EN] || pwdata[CB_CLEAR]);
	endsequence
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_err_phase: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	chk_rdata_hold: assert property
		(!(psel && !penable) |=> $stable(prdata))
		else $error("prdata changed outside setup");
	chk_misalign_err: assert property
		(s_acc ##0 paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	chk_unmapped_err: assert property
		(s_acc ##0 paddr >= 12'h0A0 |-> pslverr)
		else $error("unmapped access not refused");
	chk_ctrl_ok: assert property (s_acc ##0 paddr == OFF_CTRL |-> !pslverr)
		else $error("control access refused");
	chk_err_rdzero: assert property
		(s_acc ##0 (!pwrite && pslverr) |-> prdata == 32'h0)
		else $error("refused read not zero");
	chk_off_clears: assert property
		(s_off |-> ##[1:2] !line_unavailable)
		else $error("unavailable kept after disable");
endmodule
`default_nettype wire

// ### tpm_frm.sv
`timescale 1ns/1ps
`default_nettype none
module tpm_frm (
	input  wire logic        pclk,
	output logic      [10:0] ev
);
	initial ev = 11'h000;
	// gap 0 gives one event per frame, back to back
	task automatic pulse(input int b, input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			ev[b] <= 1'b1;
			if (gap > 0) begin
				@(posedge pclk);
				ev[b] <= 1'b0;
				repeat (gap - 1) @(posedge pclk);
			end
		end
		@(posedge pclk);
		ev[b] <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tpm_pkg::*;
	localparam int TPS  = 32;
	localparam int ISEC = 12;
	typedef struct {logic [4:0] c; int b, n, g, k, e, v;} tpm_row_s;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        line_unavailable, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] ev;
	int          errors, n_checks;
	// ctrl, event, count, gap, slot, expected count, expected event count
	tpm_row_s rows [12] = '{
		'{5'h05, 0, 1, 0, 0, 1, 1}, '{5'h05, 0, 2, 1, 3, 1, 2},
		'{5'h05, 1, 1, 0, 2, 1, 1}, '{5'h05, 3, 1, 0, 4, 1, 0},
		'{5'h05, 2, 3, 0, 5, 3, 0}, '{5'h0F, 0, 1, 0, 0, 1, 1},
		'{5'h0F, 4, 1, 0, 2, 1, 0}, '{5'h0F, 5, 1, 0, 2, 1, 0},
		'{5'h07, 6, 16, 0, 2, 1, 0}, '{5'h07, 6, 15, 0, 3, 1, 0},
		'{5'h0F, 0, 3, 1, 3, 1, 3}, '{5'h0F, 2, 2, 0, 5, 1, 0}};

	tpm_monitor #(.TICKS_PER_SEC(TPS), .INTERVAL_SECS(ISEC)) u_tpm_monitor (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .crc_err_evt(ev[0]),
		.oof_evt(ev[1]), .lof_evt(ev[2]), .slip_evt(ev[3]), .los_evt(ev[4]),
		.ais_evt(ev[5]), .fas_err_evt(ev[6]), .rai_evt(ev[7]),
		.excess_err_evt(ev[8]), .fbit_err_evt(ev[9]), .lcv_evt(ev[10]),
		.line_unavailable(line_unavailable));
	tpm_frm u_frm (.pclk(pclk), .ev(ev));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	// request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			chk("pready", 32'h1, 32'h0);
			close_out();
		end
	endtask

	task automatic rchk(input string nm, input logic [11:0] a,
			input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	// seconds are only visible through the timer, so poll it
	task automatic wait_tick;
		logic [31:0] t0;
		apb(1'b0, OFF_TIMER, 32'h0);
		t0 = rd;
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, OFF_TIMER, 32'h0);
			if (rd !== t0)
				return;
		end
		chk("tick_wait", 32'h1, 32'h0);
		close_out();
	endtask

	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		errors = 0;
		n_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rchk("ctrl_rst", OFF_CTRL, {28'h0, CTRL_RST});
		rchk("timer_rst", OFF_TIMER, 32'h0);
		apb(1'b0, 12'h0A4, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, er});
		apb(1'b0, 12'h002, 32'h0);
		chk("misalign_err", 32'h1, {31'h0, er});
		apb(1'b0, 12'h022, 32'h0);
		chk("misalign_rd", 32'h0, rd);
		$display("reset test done");
		foreach (rows[i]) begin
			apb(1'b1, OFF_CTRL, {27'h0, rows[i].c | 5'h10});
			wait_tick();
			u_frm.pulse(rows[i].b, rows[i].n, rows[i].g);
			wait_tick();
			rchk("cur", OFF_CUR + 12'(4 * rows[i].k), 32'(rows[i].e));
			rchk("events", OFF_EVENTS, 32'(rows[i].v));
			$display("row %0d done", i);
		end
		apb(1'b1, OFF_CTRL, 32'h11);
		u_frm.pulse(0, 3, 0);
		rchk("events_t1_unframed", OFF_EVENTS, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h13);
		u_frm.pulse(0, 3, 0);
		rchk("events_e1_unframed", OFF_EVENTS, 32'h0);
		rchk("timer_unframed", OFF_TIMER, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h15);
		rchk("clear_self", OFF_CTRL, 32'h5);
		for (int b = 7; b < 11; b++)
			u_frm.pulse(b, 1, 0);
		u_frm.pulse(4, 1, 0);
		rchk("flags", OFF_STATUS, 32'h1F);
		$display("unframed and flags tests done");
		apb(1'b1, OFF_CTRL, 32'h15);
		for (int j = 0; j < 2; j++) begin
			wait_tick();
			u_frm.pulse(0, 1, 0);
			for (int i = 0; i < ISEC; i++) begin
				wait_tick();
				if (rd === 32'h0)
					break;
			end
			chk("timer_wrap", 32'h0, rd);
		end
		apb(1'b1, OFF_HSEL, 32'h1);
		rchk("hist01", OFF_HIST, 32'h1);
		rchk("hstat01", OFF_HSTAT, 32'h0);
		rchk("cur_after_push", OFF_CUR, 32'h0);
		rchk("valid", OFF_STATUS, 32'h0002_0000);
		rchk("worst_tie", OFF_WORST, 32'h2);
		rchk("total", OFF_TOTAL, 32'h2);
		apb(1'b1, OFF_HSEL, 32'h3);
		rchk("hist_beyond", OFF_HIST, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h0);
		rchk("off_status", OFF_STATUS, 32'h0);
		rchk("off_worst", OFF_WORST, 32'h0);
		$display("interval test done");
		apb(1'b1, OFF_CTRL, 32'h15);
		for (int i = 0; i < 10; i++) begin
			wait_tick();
			if (i == 9)
				chk("unav_early", 32'h0, {31'h0, line_unavailable});
			u_frm.pulse(1, 1, 0);
		end
		wait_tick();
		chk("unav_on", 32'h1, {31'h0, line_unavailable});
		for (int i = 0; i < 10; i++) begin
			if (i == 9)
				chk("unav_held", 32'h1, {31'h0, line_unavailable});
			wait_tick();
		end
		chk("unav_off", 32'h0, {31'h0, line_unavailable});
		rchk("uas_cur", OFF_CUR + 12'h004, 32'h0);
		for (int i = 0; i < 10; i++) begin
			wait_tick();
			u_frm.pulse(1, 1, 0);
		end
		wait_tick();
		chk("unav_again", 32'h1, {31'h0, line_unavailable});
		apb(1'b1, OFF_CTRL, 32'h0);
		repeat (2) @(posedge pclk);
		chk("unav_disabled", 32'h0, {31'h0, line_unavailable});
		$display("unavailable test done");
		close_out();
	end
endmodule

bind tpm_monitor tpm_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.line_unavailable(line_unavailable));
`default_nettype wire
